/* hw/sics_pkg.sv */
// Constants and types for the stepper two-wire command slave
package sics_pkg;

  // --------------------------------------------------------------
  // Command codes
  // --------------------------------------------------------------
  localparam logic [7:0] SICS_STATUS_DUMP_CMD = 8'h81;
  localparam logic [7:0] SICS_POSITION_DUMP_CMD = 8'hfc;
  localparam logic [7:0] SICS_FUSE_READBACK_CMD = 8'h82;
  localparam logic [7:0] SICS_SAFE_PARK_CMD = 8'h84;
  localparam logic [7:0] SICS_ABRUPT_HALT_CMD = 8'h85;
  localparam logic [7:0] SICS_ZERO_POSITION_CMD = 8'h86;
  localparam logic [7:0] SICS_RELOAD_DEFAULTS_CMD = 8'h87;
  localparam logic [7:0] SICS_TWO_TARGET_MOVE_CMD = 8'h88;
  localparam logic [7:0] SICS_MOTOR_CONFIG_CMD = 8'h89;
  localparam logic [7:0] SICS_TARGET_LOAD_CMD = 8'h8b;
  localparam logic [7:0] SICS_RAMPED_HALT_CMD = 8'h8f;
  localparam logic [7:0] SICS_FUSE_PROGRAM_CMD = 8'h90;
  localparam logic [7:0] SICS_STALL_CONFIG_CMD = 8'h96;
  localparam logic [7:0] SICS_RUN_CONTINUOUS_CMD = 8'h97;
  localparam logic [7:0] SICS_BACK_EMF_PROBE_CMD = 8'h9f;

  // --------------------------------------------------------------
  // Action pulse positions
  // --------------------------------------------------------------
  localparam int SICS_ACT_W = 12;
  localparam int SICS_ACT_SAFE_PARK = 0;
  localparam int SICS_ACT_ABRUPT_HALT = 1;
  localparam int SICS_ACT_RAMPED_HALT = 2;
  localparam int SICS_ACT_RUN_CONT = 3;
  localparam int SICS_ACT_ZERO_POS = 4;
  localparam int SICS_ACT_RELOAD = 5;
  localparam int SICS_ACT_TWO_TARGET = 6;
  localparam int SICS_ACT_MOTOR_CFG = 7;
  localparam int SICS_ACT_TARGET_LOAD = 8;
  localparam int SICS_ACT_STALL_CFG = 9;
  localparam int SICS_ACT_FUSE_PROG = 10;
  localparam int SICS_ACT_BEMF = 11;

  // --------------------------------------------------------------
  // Addressing and framing
  // --------------------------------------------------------------
  localparam logic [1:0] SICS_ADDR_FIXED = 2'h3;
  localparam logic [6:0] SICS_GENERAL_CALL = 7'h00;
  localparam logic [2:0] SICS_RESP_HEAD = 3'h7;
  localparam logic [3:0] SICS_MAX_BYTES = 4'h8;
  localparam logic [3:0] SICS_LAST_BIT = 4'h7;
  localparam logic [3:0] SICS_ACK_SLOT = 4'h8;
  localparam logic [3:0] SICS_CMD_INDEX = 4'h1;
  localparam logic [7:0] SICS_FILL_BYTE = 8'hff;
  localparam int SICS_FRAME_W = 56;

  // --------------------------------------------------------------
  // Link phases
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    SICS_PH_IDLE,
    SICS_PH_ADDR,
    SICS_PH_WDATA,
    SICS_PH_RDATA
  } sics_phase_e;

endpackage

/* hw/sics_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/100ps
module sics_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule

/* hw/sics_slave.sv */
// Two-wire command slave of a stepper positioner
//
// Contract
// R1 - A read is a write transfer with command, then a separate read transfer.
// R2 - The command byte of the write transfer is kept as the read pointer.
// R3 - On address with read bit, device shifts response bits onto the data line.
// R4 - Master acks each response byte; a missing ack ends the device's sending.
// R5 - Every START resets the protocol and expects an address byte.
// R6 - The master never sends START directly followed by STOP.
// R7 - First byte: seven address bits MSB first, then direction bit, one is read.
// R8 - Address matching own node selects receiver or transmitter by direction bit.
// R9 - Node address is two ones, four fuse bits, one strap pin bit.
// R10 - An unconnected strap pin drives the motor to the safe park position.
// R11 - The all-zero broadcast address is acknowledged as well; the code acknowledges it only with the write bit.
// R12 - After a broadcast address the next byte is the command.
// R13 - 0x81 status dump, 0xFC position dump, 0x82 fuse readback; the code answers 0xFC and 0x82 reads with 0xFF after the address byte.
// R14 - 0x84 safe park, 0x85 abrupt halt, 0x8F ramped halt, 0x97 run.
// R15 - 0x86 zeroes the position, 0x87 reloads defaults from fuses.
// R16 - 0x88 two-target move, 0x89 motor config, 0x8B target load, 0x96 stall config.
// R17 - 0x90 programs fuses, 0x9F routes back-EMF to the aux sense pin.
// R18 - A status dump read clears the latched fault flags.
// R19 - Status byte 1: run/standstill current; byte 2: max/min speed.
// R20 - Status byte 4: restart, missed, coil, undervoltage, shutdown, warning, temp range.
// R21 - Status byte 5: movement state, switch, overcurrents, stall, pump failure.
// R22 - Status byte 6 all ones; byte 7 absolute and difference stall levels.
// R23 - At most eight bytes per transfer; further bytes are not acknowledged.
// R24 - Unknown command bytes are ignored.
`timescale 1ns/100ps
module sics_slave (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [3:0] fuse_address_in,
  input wire logic pin_address_bit_in,
  input wire logic pin_address_open_in,
  input wire logic [3:0] run_current_in,
  input wire logic [3:0] hold_current_in,
  input wire logic [3:0] max_speed_in,
  input wire logic [3:0] min_speed_in,
  input wire logic [7:0] motion_profile_in,
  input wire logic core_supply_restart_flag_in,
  input wire logic missed_pulse_flag_in,
  input wire logic coil_defect_flag_in,
  input wire logic supply_undervoltage_flag_in,
  input wire logic thermal_shutdown_flag_in,
  input wire logic thermal_warning_flag_in,
  input wire logic [1:0] temperature_range_in,
  input wire logic [2:0] movement_state_in,
  input wire logic external_switch_state_in,
  input wire logic x_coil_overcurrent_in,
  input wire logic y_coil_overcurrent_in,
  input wire logic stall_detected_in,
  input wire logic pump_failure_flag_in,
  input wire logic [3:0] absolute_stall_level_in,
  input wire logic [3:0] difference_stall_level_in,
  output logic [7:0] read_pointer_out,
  output logic safe_park_cmd_out,
  output logic abrupt_halt_cmd_out,
  output logic ramped_halt_cmd_out,
  output logic run_continuous_cmd_out,
  output logic zero_position_cmd_out,
  output logic reload_defaults_cmd_out,
  output logic two_target_move_cmd_out,
  output logic motor_config_cmd_out,
  output logic target_load_cmd_out,
  output logic stall_config_cmd_out,
  output logic fuse_program_cmd_out,
  output logic back_emf_probe_cmd_out,
  output logic status_flags_clear_out
);
  import sics_pkg::*;

  // --------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------
  function automatic logic [SICS_ACT_W-1:0] cmd_action(input logic [7:0] c);
    logic [SICS_ACT_W-1:0] a;
    a = '0;
    case (c)
      SICS_SAFE_PARK_CMD: a[SICS_ACT_SAFE_PARK] = 1'b1; // R14
      SICS_ABRUPT_HALT_CMD: a[SICS_ACT_ABRUPT_HALT] = 1'b1; // R14
      SICS_RAMPED_HALT_CMD: a[SICS_ACT_RAMPED_HALT] = 1'b1; // R14
      SICS_RUN_CONTINUOUS_CMD: a[SICS_ACT_RUN_CONT] = 1'b1; // R14
      SICS_ZERO_POSITION_CMD: a[SICS_ACT_ZERO_POS] = 1'b1; // R15
      SICS_RELOAD_DEFAULTS_CMD: a[SICS_ACT_RELOAD] = 1'b1; // R15
      SICS_TWO_TARGET_MOVE_CMD: a[SICS_ACT_TWO_TARGET] = 1'b1; // R16
      SICS_MOTOR_CONFIG_CMD: a[SICS_ACT_MOTOR_CFG] = 1'b1; // R16
      SICS_TARGET_LOAD_CMD: a[SICS_ACT_TARGET_LOAD] = 1'b1; // R16
      SICS_STALL_CONFIG_CMD: a[SICS_ACT_STALL_CFG] = 1'b1; // R16
      SICS_FUSE_PROGRAM_CMD: a[SICS_ACT_FUSE_PROG] = 1'b1; // R17
      SICS_BACK_EMF_PROBE_CMD: a[SICS_ACT_BEMF] = 1'b1; // R17
      default: a = '0;
    endcase
    return a;
  endfunction

  function automatic logic cmd_known(input logic [7:0] c);
    return (cmd_action(c) != '0) || (c == SICS_STATUS_DUMP_CMD) ||
           (c == SICS_POSITION_DUMP_CMD) || (c == SICS_FUSE_READBACK_CMD); // R13 R24
  endfunction

  // --------------------------------------------------------------
  // Link domain signals
  // --------------------------------------------------------------
  logic [6:0] link_raw;
  logic [6:0] link_s;
  logic scl_s;
  logic sda_s;
  logic [3:0] fuse_s;
  logic pin_s;
  logic scl_p_q;
  logic sda_p_q;
  logic start_w;
  logic stop_w;
  logic rise_w;
  logic fall_w;
  sics_phase_e phase_q;
  logic [3:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic txen_q;
  logic drive_q;
  logic [3:0] byte_q;
  logic [7:0] cmd_q;
  logic cmd_tgl_q;
  logic [6:0] node_addr;
  logic addr_hit;

  // Frame snapshot held in the system domain
  logic [SICS_FRAME_W-1:0] frame_q;

  // --------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------
  assign link_raw = {pin_address_bit_in, fuse_address_in, sda_in, scl_in};

  sics_sync #(.W(7)) u_link_sync (
    .clk_in(link_clk_in),
    .resetn_in(resetn_in),
    .d_in(link_raw),
    .q_out(link_s)
  );

  assign scl_s = link_s[0];
  assign sda_s = link_s[1];
  assign fuse_s = link_s[5:2];
  assign pin_s = link_s[6];

  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign start_w = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_w = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign rise_w = scl_s && !scl_p_q;
  assign fall_w = !scl_s && scl_p_q;

  // --------------------------------------------------------------
  // Addressing
  // --------------------------------------------------------------
  assign node_addr = {SICS_ADDR_FIXED, fuse_s, pin_s}; // R9
  assign addr_hit = (rx_q[7:1] == node_addr) || // R7 R8
                    ((rx_q[7:1] == SICS_GENERAL_CALL) && !rx_q[0]); // R11

  // --------------------------------------------------------------
  // Response byte selection
  // --------------------------------------------------------------
  function automatic logic [7:0] resp_byte(input logic [3:0] idx, input logic [7:0] ptr,
                                           input logic [6:0] addr, input logic [SICS_FRAME_W-1:0] fr);
    logic [7:0] b;
    b = SICS_FILL_BYTE;
    if (idx == 4'h0) begin
      b = {1'b1, addr};
    end else if ((ptr == SICS_STATUS_DUMP_CMD) && (idx < SICS_MAX_BYTES)) begin
      b = fr[SICS_FRAME_W-8*idx +: 8]; // R19 R20 R21 R22
    end
    return b;
  endfunction

  // --------------------------------------------------------------
  // Link protocol engine
  // --------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_q <= SICS_PH_IDLE;
      cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'hff;
      txen_q <= 1'b0;
      drive_q <= 1'b0;
      byte_q <= 4'h0;
      cmd_q <= 8'h00;
      cmd_tgl_q <= 1'b0;
    end else if (start_w) begin
      phase_q <= SICS_PH_ADDR; // R5
      // Next SCL fall only closes the start, not a data bit
      cnt_q <= SICS_ACK_SLOT;
      txen_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (stop_w) begin
      phase_q <= SICS_PH_IDLE;
      txen_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (phase_q != SICS_PH_IDLE) begin
      if (rise_w) begin
        if (cnt_q < SICS_ACK_SLOT) begin
          rx_q <= {rx_q[6:0], sda_s}; // R7
        end else if ((phase_q == SICS_PH_RDATA) && sda_s) begin
          phase_q <= SICS_PH_IDLE; // R4
          txen_q <= 1'b0;
        end
      end else if (fall_w) begin
        if (cnt_q == SICS_LAST_BIT) begin
          cnt_q <= SICS_ACK_SLOT;
          txen_q <= 1'b0;
          case (phase_q)
            SICS_PH_ADDR: begin
              if (addr_hit) begin
                drive_q <= 1'b1; // R8 R11
                phase_q <= rx_q[0] ? SICS_PH_RDATA : SICS_PH_WDATA; // R1 R3
                byte_q <= rx_q[0] ? 4'h0 : SICS_CMD_INDEX;
              end else begin
                phase_q <= SICS_PH_IDLE;
              end
            end
            SICS_PH_WDATA: begin
              if (byte_q < SICS_MAX_BYTES) begin
                drive_q <= 1'b1;
                byte_q <= byte_q + 4'h1;
              end else begin
                drive_q <= 1'b0; // R23
              end
              if ((byte_q == SICS_CMD_INDEX) && cmd_known(rx_q)) begin
                cmd_q <= rx_q; // R2 R12
                cmd_tgl_q <= !cmd_tgl_q;
              end
            end
            default: begin
              drive_q <= 1'b0;
            end
          endcase
        end else if (cnt_q == SICS_ACK_SLOT) begin
          cnt_q <= 4'h0;
          drive_q <= 1'b0;
          if (phase_q == SICS_PH_RDATA) begin
            tx_q <= resp_byte(byte_q, cmd_q, node_addr, frame_q); // R3
            txen_q <= 1'b1;
            byte_q <= byte_q + 4'h1;
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
          if (txen_q) begin
            tx_q <= {tx_q[6:0], 1'b1};
          end
        end
      end
    end
  end

  // Open drain: only low is ever driven
  assign sda_out = 1'b0;
  assign sda_oe_out = drive_q || (txen_q && !tx_q[7]);

  // --------------------------------------------------------------
  // System domain crossing
  // --------------------------------------------------------------
  logic [2:0] sys_raw;
  logic [2:0] sys_s;
  logic tgl_p_q;
  logic busy_p_q;
  logic open_p_q;
  logic tgl_edge;
  logic [7:0] ptr_q;
  logic [SICS_ACT_W-1:0] act_q;
  logic clear_q;

  assign sys_raw = {pin_address_open_in, (phase_q == SICS_PH_RDATA), cmd_tgl_q};

  sics_sync #(.W(3)) u_sys_sync (
    .clk_in(clk_sys_in),
    .resetn_in(resetn_in),
    .d_in(sys_raw),
    .q_out(sys_s)
  );

  assign tgl_edge = sys_s[0] ^ tgl_p_q;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tgl_p_q <= 1'b0;
      busy_p_q <= 1'b0;
      open_p_q <= 1'b0;
    end else begin
      tgl_p_q <= sys_s[0];
      busy_p_q <= sys_s[1];
      open_p_q <= sys_s[2];
    end
  end

  // --------------------------------------------------------------
  // Command pointer and action pulses
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr_q <= 8'h00;
    end else if (tgl_edge) begin
      ptr_q <= cmd_q; // R2
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_q <= '0;
    end else begin
      act_q <= tgl_edge ? cmd_action(cmd_q) : '0;
      if (sys_s[2] && !open_p_q) begin
        act_q[SICS_ACT_SAFE_PARK] <= 1'b1; // R10
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= busy_p_q && !sys_s[1] && (ptr_q == SICS_STATUS_DUMP_CMD); // R18
    end
  end

  // Snapshot frozen while a read is in progress
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frame_q <= '0;
    end else if (!sys_s[1] && !busy_p_q) begin
      frame_q <= {run_current_in, hold_current_in, // R19
                  max_speed_in, min_speed_in, // R19
                  motion_profile_in,
                  core_supply_restart_flag_in, missed_pulse_flag_in, coil_defect_flag_in, // R20
                  supply_undervoltage_flag_in, thermal_shutdown_flag_in, thermal_warning_flag_in,
                  temperature_range_in,
                  movement_state_in, external_switch_state_in, x_coil_overcurrent_in, // R21
                  y_coil_overcurrent_in, stall_detected_in, pump_failure_flag_in,
                  SICS_FILL_BYTE, // R22
                  absolute_stall_level_in, difference_stall_level_in}; // R22
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign read_pointer_out = ptr_q;
  assign safe_park_cmd_out = act_q[SICS_ACT_SAFE_PARK];
  assign abrupt_halt_cmd_out = act_q[SICS_ACT_ABRUPT_HALT];
  assign ramped_halt_cmd_out = act_q[SICS_ACT_RAMPED_HALT];
  assign run_continuous_cmd_out = act_q[SICS_ACT_RUN_CONT];
  assign zero_position_cmd_out = act_q[SICS_ACT_ZERO_POS];
  assign reload_defaults_cmd_out = act_q[SICS_ACT_RELOAD];
  assign two_target_move_cmd_out = act_q[SICS_ACT_TWO_TARGET];
  assign motor_config_cmd_out = act_q[SICS_ACT_MOTOR_CFG];
  assign target_load_cmd_out = act_q[SICS_ACT_TARGET_LOAD];
  assign stall_config_cmd_out = act_q[SICS_ACT_STALL_CFG];
  assign fuse_program_cmd_out = act_q[SICS_ACT_FUSE_PROG];
  assign back_emf_probe_cmd_out = act_q[SICS_ACT_BEMF];
  assign status_flags_clear_out = clear_q;

endmodule

/* tb/sics_slave_asserts.sv */
// Port checks of the two-wire command slave
`timescale 1ns/100ps
module sics_slave_asserts (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_out,
  input wire logic pin_address_open_in,
  input wire logic [7:0] read_pointer_out,
  input wire logic safe_park_cmd_out,
  input wire logic abrupt_halt_cmd_out,
  input wire logic back_emf_probe_cmd_out,
  input wire logic status_flags_clear_out
);
  import sics_pkg::*;

  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_park;
    ##[1:5] safe_park_cmd_out ##1 !safe_park_cmd_out;
  endsequence

  property p_start_quiet;
    @(posedge link_clk_in) disable iff (!resetn_in) s_start |=> !sda_oe_out [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("data pulled just after start");
  property p_oe_scl_low;
    @(posedge link_clk_in) disable iff (!resetn_in) $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with clock high");
  property p_park_pin;
    @(posedge clk_sys_in) disable iff (!resetn_in) $rose(pin_address_open_in) |-> s_park;
  endproperty
  a_park_pin: assert property (p_park_pin) else $error("no park pulse for open strap");
  property p_halt_ptr;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      abrupt_halt_cmd_out |-> ##[0:1] read_pointer_out == SICS_ABRUPT_HALT_CMD;
  endproperty
  a_halt_ptr: assert property (p_halt_ptr) else $error("halt pulse without halt code");
  property p_bemf_ptr;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      back_emf_probe_cmd_out |=> read_pointer_out == SICS_BACK_EMF_PROBE_CMD && !back_emf_probe_cmd_out;
  endproperty
  a_bemf_ptr: assert property (p_bemf_ptr) else $error("probe pulse wrong");
  property p_clear_ptr;
    @(posedge clk_sys_in) disable iff (!resetn_in) status_flags_clear_out |-> read_pointer_out == SICS_STATUS_DUMP_CMD;
  endproperty
  a_clear_ptr: assert property (p_clear_ptr) else $error("flag clear without status pointer");
  property p_clear_once;
    @(posedge clk_sys_in) disable iff (!resetn_in) $rose(status_flags_clear_out) |=> !status_flags_clear_out [*3];
  endproperty
  a_clear_once: assert property (p_clear_once) else $error("flag clear too long");
  property p_ptr_known;
    @(posedge clk_sys_in) disable iff (!resetn_in) $changed(read_pointer_out) |->
      read_pointer_out inside {[8'h81:8'h82], [8'h84:8'h89], 8'h8b, 8'h8f, 8'h90, 8'h96, 8'h97, 8'h9f, 8'hfc};
  endproperty
  a_ptr_known: assert property (p_ptr_known) else $error("pointer took unknown code");
endmodule

bind sics_slave sics_slave_asserts u_asserts (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
  .link_clk_in(link_clk_in), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_out(sda_oe_out),
  .pin_address_open_in(pin_address_open_in), .read_pointer_out(read_pointer_out),
  .safe_park_cmd_out(safe_park_cmd_out), .abrupt_halt_cmd_out(abrupt_halt_cmd_out),
  .back_emf_probe_cmd_out(back_emf_probe_cmd_out), .status_flags_clear_out(status_flags_clear_out));

/* tb/sics_master.sv */
// Behavioural two-wire bus master
`timescale 1ns/100ps
module sics_master #(
  parameter int QTR = 100
) (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // One bit slot, left with the clock low
  task automatic bit_slot(input logic b, output logic r);
    sda_pull_out = !b;
    #QTR;
    scl_out = 1'b1;
    #QTR;
    r = sda_in;
    #QTR;
    scl_out = 1'b0;
    #QTR;
  endtask
  task automatic start_cond();
    sda_pull_out = 1'b0;
    #QTR;
    scl_out = 1'b1;
    #QTR;
    sda_pull_out = 1'b1;
    #QTR;
    scl_out = 1'b0;
    #QTR;
  endtask
  // Only issued after a whole byte
  task automatic stop_cond();
    sda_pull_out = 1'b1;
    #QTR;
    scl_out = 1'b1;
    #QTR;
    sda_pull_out = 1'b0;
    #(2 * QTR);
  endtask
  // Byte then acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], r[i]);
    end
    bit_slot(!ack_in, a);
    ack = !a;
  endtask
endmodule

/* tb/tb_stepper_i2c_command_slave.sv */
// Self-checking bench of the two-wire command slave
`timescale 1ns/100ps
module tb_stepper_i2c_command_slave;
  import sics_pkg::*;
  logic clk_sys_in = 1'b0;
  logic link_clk = 1'b0;
  logic resetn, pin_open, pin_bit, dut_sda, dut_oe, m_pull, scl, clr, clr_seen, ak, r, obs_rst;
  logic [3:0] fuse;
  logic [7:0] b1, b2, b3, b4, b5, b7, ptr, rd;
  logic [11:0] seen;
  wire [11:0] act;
  wire sda = !((dut_oe && !dut_sda) || m_pull);
  int errors = 0;
  int n_checks = 0;
  // Three read codes, then action codes in output bit order
  logic [7:0] cmds [15] = '{8'h81, 8'hfc, 8'h82, 8'h84, 8'h85, 8'h8f, 8'h97, 8'h86, 8'h87, 8'h88, 8'h89,
    8'h8b, 8'h96, 8'h90, 8'h9f};

  always #20 clk_sys_in = !clk_sys_in;
  always #6 link_clk = !link_clk;

  sics_slave u_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn), .link_clk_in(link_clk), .scl_in(scl),
    .sda_in(sda), .sda_out(dut_sda), .sda_oe_out(dut_oe), .fuse_address_in(fuse), .pin_address_bit_in(pin_bit),
    .pin_address_open_in(pin_open), .run_current_in(b1[7:4]), .hold_current_in(b1[3:0]),
    .max_speed_in(b2[7:4]), .min_speed_in(b2[3:0]), .motion_profile_in(b3),
    .core_supply_restart_flag_in(b4[7]), .missed_pulse_flag_in(b4[6]), .coil_defect_flag_in(b4[5]),
    .supply_undervoltage_flag_in(b4[4]), .thermal_shutdown_flag_in(b4[3]), .thermal_warning_flag_in(b4[2]),
    .temperature_range_in(b4[1:0]), .movement_state_in(b5[7:5]), .external_switch_state_in(b5[4]),
    .x_coil_overcurrent_in(b5[3]), .y_coil_overcurrent_in(b5[2]), .stall_detected_in(b5[1]),
    .pump_failure_flag_in(b5[0]), .absolute_stall_level_in(b7[7:4]), .difference_stall_level_in(b7[3:0]),
    .read_pointer_out(ptr), .safe_park_cmd_out(act[0]), .abrupt_halt_cmd_out(act[1]),
    .ramped_halt_cmd_out(act[2]), .run_continuous_cmd_out(act[3]), .zero_position_cmd_out(act[4]),
    .reload_defaults_cmd_out(act[5]), .two_target_move_cmd_out(act[6]), .motor_config_cmd_out(act[7]),
    .target_load_cmd_out(act[8]), .stall_config_cmd_out(act[9]), .fuse_program_cmd_out(act[10]),
    .back_emf_probe_cmd_out(act[11]), .status_flags_clear_out(clr));
  sics_master u_mst (.sda_in(sda), .scl_out(scl), .sda_pull_out(m_pull));

  always @(posedge clk_sys_in) begin
    seen <= obs_rst ? '0 : seen | act;
    clr_seen <= !obs_rst && (clr_seen || clr);
  end

  // Clear the pulse observers over one clock
  task automatic obs_clear();
    obs_rst = 1'b1;
    @(posedge clk_sys_in) #1;
    obs_rst = 1'b0;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [6:0] node();
    return {2'h3, fuse, pin_bit};
  endfunction
  function automatic logic [7:0] resp(input int i);
    logic [71:0] f;
    f = {3'h7, fuse, pin_bit, b1, b2, b3, b4, b5, 8'hff, b7, 8'hff};
    return f[71 - 8 * i -: 8];
  endfunction
  task automatic wr_cmd(input logic [6:0] a, input logic [7:0] c, input logic exp_ack);
    u_mst.start_cond();
    u_mst.xfer({a, 1'b0}, 1'b0, rd, ak);
    check({15'h0, ak}, {15'h0, exp_ack});
    if (exp_ack) begin
      u_mst.xfer(c, 1'b0, rd, ak);
      check({15'h0, ak}, 16'h1);
    end
    u_mst.stop_cond();
  endtask
  task automatic wait_ptr(input logic [7:0] c);
    int n;
    n = 0;
    while (ptr !== c && n < 400) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n == 400) begin
      errors++;
      stop_test();
    end
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic read_back(input logic [7:0] c);
    @(posedge clk_sys_in) #1;
    {b1, b2, b3, b4, b5, b7} = 48'({$urandom, $urandom});
    wr_cmd(node(), c, 1'b1);
    wait_ptr(c);
    obs_clear();
    u_mst.start_cond();
    u_mst.xfer({node(), 1'b1}, 1'b0, rd, ak);
    check({15'h0, ak}, 16'h1);
    for (int i = 0; i < 9; i++) begin
      u_mst.xfer(8'hff, i < 8, rd, ak);
      check({8'h0, rd}, {8'h0, c == 8'h81 || i == 0 ? resp(i) : 8'hff});
    end
    u_mst.stop_cond();
    repeat (10) @(posedge clk_sys_in);
    #1;
    check({15'h0, clr_seen}, {15'h0, c == 8'h81});
  endtask

  initial begin
    logic [7:0] c;
    resetn = 1'b0;
    pin_open = 1'b0;
    pin_bit = 1'b0;
    fuse = 4'h0;
    {b1, b2, b3, b4, b5, b7} = '0;
    obs_rst = 1'b1;
    c = 8'($urandom(32'h9d85ba87));
    repeat (8) @(posedge clk_sys_in);
    #1 resetn = 1'b1;
    check({8'h0, ptr}, 16'h0);
    repeat (4) @(posedge clk_sys_in);
    for (int i = 0; i < 15; i++) begin
      @(posedge clk_sys_in) #1;
      {fuse, pin_bit} = 5'($urandom);
      obs_clear();
      wr_cmd(node(), cmds[i], 1'b1);
      wait_ptr(cmds[i]);
      check({8'h0, ptr}, {8'h0, cmds[i]});
      check({4'h0, seen}, i < 3 ? 16'h0 : 16'h1 << (i - 3));
    end
    for (int i = 0; i < 2; i++) begin
      obs_clear();
      wr_cmd(node(), i ? 8'h83 : {2'h0, 6'($urandom)}, 1'b1);
      repeat (20) @(posedge clk_sys_in);
      check({8'h0, ptr}, {8'h0, cmds[14]});
      check({4'h0, seen}, 16'h0);
    end
    wr_cmd(node() ^ {2'h0, 5'($urandom) | 5'h01}, 8'h85, 1'b0);
    obs_clear();
    wr_cmd(SICS_GENERAL_CALL, 8'h85, 1'b1);
    wait_ptr(8'h85);
    check({4'h0, seen}, 16'h2);
    u_mst.start_cond();
    u_mst.xfer({SICS_GENERAL_CALL, 1'b1}, 1'b0, rd, ak);
    check({15'h0, ak}, 16'h0);
    u_mst.stop_cond();
    obs_clear();
    u_mst.start_cond();
    repeat (3) u_mst.bit_slot(1'b1, r);
    wr_cmd(node(), 8'h8f, 1'b1);
    wait_ptr(8'h8f);
    check({4'h0, seen}, 16'h4);
    u_mst.start_cond();
    u_mst.xfer({node(), 1'b0}, 1'b0, rd, ak);
    for (int i = 1; i < 9; i++) begin
      u_mst.xfer(i == 1 ? 8'h89 : 8'($urandom), 1'b0, rd, ak);
      check({15'h0, ak}, {15'h0, i < 8});
    end
    u_mst.stop_cond();
    read_back(8'h81);
    read_back(8'hfc);
    read_back(8'h82);
    @(posedge clk_sys_in) #1;
    obs_clear();
    pin_open = 1'b1;
    repeat (8) @(posedge clk_sys_in);
    check({4'h0, seen}, 16'h1);
    #1 resetn = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    check({8'h0, ptr}, 16'h0);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk_sys_in);
    read_back(8'h81);
    stop_test();
  end
endmodule
